// [pllcgm_pkg.sv]
// Purpose: Shared constants and types for the clock generation and monitor block.
// Assumes: Single 20 MHz system clock; oscillator and synthesizer clocks arrive as pins.
// Notes:   Monitor and checker counts are repeated as top-level parameter defaults.

// ****************************************************************
// Package
// ****************************************************************
package pllcgm_pkg;

  // Field widths
  localparam int REFDIV_W = 4;
  localparam int MULT_W = 6;

  // Values after reset
  localparam logic RST_SELF_CLOCK_ENABLE = 1'b1;
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_TRACK = 1'b0;
  localparam logic RST_SYNTH_SEL = 1'b0;

  // System clock rate and monitor timeout
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int MON_TIMEOUT_US = 100;
  localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_US * CLK_FREQ_KHZ) / 1000;

  // Quality check window, in minimum-frequency synthesizer cycles
  localparam int QC_WINDOW_CYC = 50000;
  // Oscillator edges that declare the oscillator good
  localparam int QC_OSC_OK_EDGES = 4096;
  // Window repetitions before failure is flagged, zero means endless
  localparam int QC_MAX_WINDOWS = 0;

  // Source switch: oscillator then synthesizer edges
  localparam int SW_OSC_EDGES = 4;
  localparam int SW_SYN_EDGES = 4;

  // Lock detector: reference pulses per comparison and tolerances
  localparam int LOCK_WIN = 16;
  localparam int LOCK_TOL = 1;
  localparam int UNLOCK_TOL = 2;
  localparam int TRACK_TOL = 2;
  localparam int UNTRACK_TOL = 4;

  // Source switch sequencer
  typedef enum logic [1:0] {
    PLLCGM_SW_RUN = 2'b00,
    PLLCGM_SW_OSC = 2'b01,
    PLLCGM_SW_SYN = 2'b10
  } pllcgm_sw_t;

  // Quality checker
  typedef enum logic {
    PLLCGM_QC_IDLE = 1'b0,
    PLLCGM_QC_CHECK = 1'b1
  } pllcgm_qc_t;

  // Distance between a measured count and its target
  function automatic logic [7:0] pllcgm_abs_diff(input logic [7:0] a, input logic [7:0] b);
    pllcgm_abs_diff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction : pllcgm_abs_diff

endpackage : pllcgm_pkg

// [pllcgm_div.sv]
// Purpose: Programmable pulse divider for the reference and feedback paths.
// Assumes: tick is a one-cycle pulse on clk; ratio_m1 is the ratio minus one.
// Notes:   A ratio change takes effect on the next wrap or sooner.

`timescale 1ns/100ps
`default_nettype none

module pllcgm_div #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Input edges and ratio
  input wire logic tick,
  input wire logic [W-1:0] ratio_m1,
  // Divided pulse
  output logic pulse
);

  logic [W-1:0] count_reg;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Compare with >= so a lowered ratio never strands the counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (count_reg >= ratio_m1) begin
          count_reg <= '0;
          pulse <= 1'b1;
        end else begin
          count_reg <= W'(count_reg + 1'b1);
        end
      end
    end
  end

endmodule : pllcgm_div

`default_nettype wire

// [pllcgm_top.sv]
// Purpose: Clock synthesis control, source switching, clock monitor and quality checker.
// Assumes: Clocks on pins are far slower than clk; VCO and filter are analog, outside.
// Notes:   Generated clocks are sampled replicas stepped on clk.

`timescale 1ns/100ps
`default_nettype none

module pllcgm_top #(
  parameter int MON_CYC = pllcgm_pkg::MON_TIMEOUT_CYC,
  parameter int QC_WIN = pllcgm_pkg::QC_WINDOW_CYC,
  parameter int QC_OK = pllcgm_pkg::QC_OSC_OK_EDGES,
  parameter int QC_MAX = pllcgm_pkg::QC_MAX_WINDOWS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Clock pins
  input wire logic osc_clock,
  input wire logic synth_clock,
  // Synthesizer control
  input wire logic [pllcgm_pkg::REFDIV_W-1:0] reference_divider,
  input wire logic [pllcgm_pkg::MULT_W-1:0] loop_multiplier,
  input wire logic synth_power_on,
  input wire logic auto_bandwidth,
  input wire logic acquire_mode,
  input wire logic lock_change_irq_enable,
  input wire logic synth_source_select,
  // Monitor control
  input wire logic monitor_enable,
  input wire logic self_clock_enable_wr,
  input wire logic self_clock_enable_wdata,
  // Quality check triggers
  input wire logic por_event,
  input wire logic lvr_event,
  input wire logic stop_wake_event,
  // Synthesizer status and analog control
  output logic lock_flag,
  output logic track_flag,
  output logic lock_irq,
  output logic filter_acquire,
  output logic synth_enable,
  output logic regulator_enable,
  // Clocks and switching
  output logic synth_source_active,
  output logic core_clock,
  output logic bus_clock,
  output logic external_bus_clock_pin,
  output logic cpu_halt,
  // Monitor and checker status
  output logic self_clock_enable,
  output logic self_clock_mode,
  output logic monitor_fail,
  output logic monitor_reset,
  output logic qc_active,
  output logic osc_ok,
  output logic qc_fail
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] osc_sync_reg;
  logic [2:0] syn_sync_reg;
  logic osc_lvl_reg;
  logic syn_lvl_reg;
  logic osc_rise;
  logic syn_rise;

  // Three flops; a level counts once the last two agree
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_sync_reg <= 3'h0;
      syn_sync_reg <= 3'h0;
      osc_lvl_reg <= 1'b0;
      syn_lvl_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[1:0], osc_clock};
      syn_sync_reg <= {syn_sync_reg[1:0], synth_clock};
      if (osc_sync_reg[1] == osc_sync_reg[2]) osc_lvl_reg <= osc_sync_reg[2];
      if (syn_sync_reg[1] == syn_sync_reg[2]) syn_lvl_reg <= syn_sync_reg[2];
    end
  end

  assign osc_rise = (osc_sync_reg[1] == osc_sync_reg[2]) & osc_sync_reg[2] & ~osc_lvl_reg;
  assign syn_rise = (syn_sync_reg[1] == syn_sync_reg[2]) & syn_sync_reg[2] & ~syn_lvl_reg;

  // In self-clock mode the synthesizer stands in for the oscillator
  logic eff_osc_rise;
  logic eff_osc_lvl;
  assign eff_osc_rise = self_clock_mode ? syn_rise : osc_rise;
  assign eff_osc_lvl = self_clock_mode ? syn_lvl_reg : osc_lvl_reg;

  // ****************************************************************
  // Dividers and lock detector
  // ****************************************************************
  logic ref_pulse;
  logic fb_pulse;
  logic [6:0] fb_ratio_m1;

  // Feedback ratio 2(m+1) minus one is the multiplier with a one appended
  assign fb_ratio_m1 = {loop_multiplier, 1'b1};

  pllcgm_div #(.W(pllcgm_pkg::REFDIV_W)) u_ref_div (
    .clk(clk),
    .rst(rst),
    .tick(eff_osc_rise),
    .ratio_m1(reference_divider),
    .pulse(ref_pulse)
  );

  pllcgm_div #(.W(7)) u_fb_div (
    .clk(clk),
    .rst(rst),
    .tick(syn_rise),
    .ratio_m1(fb_ratio_m1),
    .pulse(fb_pulse)
  );

  logic [7:0] ref_cnt_reg;
  logic [7:0] fb_cnt_reg;
  logic [7:0] fb_cnt_now;
  logic [7:0] diff;
  logic win_end;
  logic auto_track_reg;
  logic detector_run;

  assign detector_run = synth_enable;
  assign win_end = ref_pulse && (ref_cnt_reg == 8'(pllcgm_pkg::LOCK_WIN - 1));
  assign fb_cnt_now = (fb_pulse && fb_cnt_reg != 8'hFF) ? 8'(fb_cnt_reg + 1'b1) : fb_cnt_reg;
  assign diff = pllcgm_pkg::pllcgm_abs_diff(fb_cnt_now, 8'(pllcgm_pkg::LOCK_WIN));

  // Count feedback pulses over a fixed number of reference pulses
  always_ff @(posedge clk) begin
    if (rst || !detector_run) begin
      ref_cnt_reg <= 8'h00;
      fb_cnt_reg <= 8'h00;
    end else if (win_end) begin
      ref_cnt_reg <= 8'h00;
      fb_cnt_reg <= 8'h00;
    end else begin
      if (ref_pulse) ref_cnt_reg <= 8'(ref_cnt_reg + 1'b1);
      fb_cnt_reg <= fb_cnt_now;
    end
  end

  // Lock with hysteresis; interrupt pulse on each window-end change while lock_change_irq_enable is set
  always_ff @(posedge clk) begin
    if (rst || !detector_run) begin
      lock_flag <= pllcgm_pkg::RST_LOCK;
      lock_irq <= 1'b0;
    end else begin
      lock_irq <= 1'b0;
      if (win_end) begin
        if (!lock_flag && diff <= 8'(pllcgm_pkg::LOCK_TOL)) begin
          lock_flag <= 1'b1;
          lock_irq <= lock_change_irq_enable;
        end else if (lock_flag && diff > 8'(pllcgm_pkg::UNLOCK_TOL)) begin
          lock_flag <= 1'b0;
          lock_irq <= lock_change_irq_enable;
        end
      end
    end
  end

  // Automatic tracking decision with its own hysteresis
  always_ff @(posedge clk) begin
    if (rst || !detector_run) begin
      auto_track_reg <= pllcgm_pkg::RST_TRACK;
    end else if (win_end) begin
      if (diff <= 8'(pllcgm_pkg::TRACK_TOL)) auto_track_reg <= 1'b1;
      else if (diff > 8'(pllcgm_pkg::UNTRACK_TOL)) auto_track_reg <= 1'b0;
    end
  end

  // Filter mode: detector in automatic, software bit in manual
  always_ff @(posedge clk) begin
    if (rst) begin
      filter_acquire <= 1'b1;
      track_flag <= pllcgm_pkg::RST_TRACK;
    end else if (auto_bandwidth) begin
      filter_acquire <= ~auto_track_reg;
      track_flag <= auto_track_reg;
    end else begin
      filter_acquire <= acquire_mode;
      track_flag <= ~acquire_mode;
    end
  end

  // ****************************************************************
  // Clock monitor
  // ****************************************************************
  logic [31:0] mon_cnt_reg;
  logic mon_expired;
  logic mon_fail_evt;

  assign mon_expired = (mon_cnt_reg == 32'(MON_CYC - 1));
  // Fires once per loss; edges returning re-arm it
  assign mon_fail_evt = monitor_enable && mon_expired && !osc_rise;

  always_ff @(posedge clk) begin
    if (rst || osc_rise || !monitor_enable) begin
      mon_cnt_reg <= 32'h0000_0000;
    end else if (mon_cnt_reg < 32'(MON_CYC)) begin
      // Saturates past the timeout so one loss never fires twice
      mon_cnt_reg <= 32'(mon_cnt_reg + 1'b1);
    end
  end

  // Failure handling: self-clock mode or a monitor reset
  always_ff @(posedge clk) begin
    if (rst) begin
      monitor_fail <= 1'b0;
      monitor_reset <= 1'b0;
      self_clock_mode <= 1'b0;
    end else begin
      monitor_fail <= mon_fail_evt;
      monitor_reset <= mon_fail_evt && !self_clock_enable;
      if (mon_fail_evt && self_clock_enable) self_clock_mode <= 1'b1;
      else if (osc_ok) self_clock_mode <= 1'b0;
    end
  end

  // Software writes win except against a monitor reset
  always_ff @(posedge clk) begin
    if (rst) begin
      self_clock_enable <= pllcgm_pkg::RST_SELF_CLOCK_ENABLE;
    end else if (mon_fail_evt && !self_clock_enable) begin
      self_clock_enable <= 1'b1;
    end else if (self_clock_enable_wr) begin
      self_clock_enable <= self_clock_enable_wdata;
    end
  end

  // ****************************************************************
  // Clock quality checker
  // ****************************************************************
  pllcgm_pkg::pllcgm_qc_t qc_state_reg;
  logic [15:0] qc_win_reg;
  logic [12:0] qc_edge_reg;
  logic [7:0] qc_tries_reg;
  logic qc_trigger;

  assign qc_trigger = por_event || lvr_event || stop_wake_event || mon_fail_evt;

  // Also started by a monitor failure; its osc_ok ends self-clock mode above
  always_ff @(posedge clk) begin
    if (rst) begin
      qc_state_reg <= pllcgm_pkg::PLLCGM_QC_IDLE;
      qc_win_reg <= 16'h0000;
      qc_edge_reg <= 13'h0000;
      qc_tries_reg <= 8'h00;
      osc_ok <= 1'b0;
      qc_fail <= 1'b0;
    end else begin
      osc_ok <= 1'b0;
      if (qc_trigger) begin
        qc_state_reg <= pllcgm_pkg::PLLCGM_QC_CHECK;
        qc_win_reg <= 16'h0000;
        qc_edge_reg <= 13'h0000;
        qc_tries_reg <= 8'h00;
        qc_fail <= 1'b0;
      end else begin
        unique case (qc_state_reg)
          pllcgm_pkg::PLLCGM_QC_IDLE: begin
            qc_win_reg <= 16'h0000;
          end
          pllcgm_pkg::PLLCGM_QC_CHECK: begin
            if (osc_rise && qc_edge_reg == 13'(QC_OK - 1)) begin
              osc_ok <= 1'b1;
              qc_state_reg <= pllcgm_pkg::PLLCGM_QC_IDLE;
            end else if (syn_rise && qc_win_reg == 16'(QC_WIN - 1)) begin
              qc_win_reg <= 16'h0000;
              qc_edge_reg <= 13'h0000;
              qc_tries_reg <= 8'(qc_tries_reg + 1'b1);
              if (QC_MAX != 0 && qc_tries_reg == 8'(QC_MAX - 1)) begin
                qc_fail <= 1'b1;
                qc_state_reg <= pllcgm_pkg::PLLCGM_QC_IDLE;
              end
            end else begin
              if (syn_rise) qc_win_reg <= 16'(qc_win_reg + 1'b1);
              if (osc_rise) qc_edge_reg <= 13'(qc_edge_reg + 1'b1);
            end
          end
        endcase
      end
    end
  end

  // Checker, selection, self-clock mode or software keep the synthesizer powered; only the checker enables the regulator
  always_ff @(posedge clk) begin
    if (rst) begin
      qc_active <= 1'b0;
      synth_enable <= 1'b0;
      regulator_enable <= 1'b0;
    end else begin
      qc_active <= (qc_state_reg == pllcgm_pkg::PLLCGM_QC_CHECK);
      synth_enable <= synth_power_on || synth_source_active ||
                      (qc_state_reg == pllcgm_pkg::PLLCGM_QC_CHECK) || self_clock_mode;
      regulator_enable <= (qc_state_reg == pllcgm_pkg::PLLCGM_QC_CHECK);
    end
  end

  // ****************************************************************
  // Source switch and clock generation
  // ****************************************************************
  pllcgm_pkg::pllcgm_sw_t sw_state_reg;
  logic [2:0] sw_cnt_reg;
  logic sel_req;
  logic src_rise;
  logic src_lvl;

  // Self-clock mode drops the synthesizer selection
  assign sel_req = synth_source_select && !self_clock_mode;
  assign src_rise = synth_source_active ? syn_rise : eff_osc_rise;
  assign src_lvl = synth_source_active ? syn_lvl_reg : eff_osc_lvl;

  // Wait 4 oscillator then 4 synthesizer edges before switching
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_state_reg <= pllcgm_pkg::PLLCGM_SW_RUN;
      sw_cnt_reg <= 3'h0;
      synth_source_active <= pllcgm_pkg::RST_SYNTH_SEL;
      cpu_halt <= 1'b0;
    end else begin
      unique case (sw_state_reg)
        pllcgm_pkg::PLLCGM_SW_RUN: begin
          sw_cnt_reg <= 3'h0;
          if (sel_req != synth_source_active) begin
            sw_state_reg <= pllcgm_pkg::PLLCGM_SW_OSC;
            cpu_halt <= 1'b1;
          end
        end
        pllcgm_pkg::PLLCGM_SW_OSC: begin
          if (eff_osc_rise) begin
            if (sw_cnt_reg == 3'(pllcgm_pkg::SW_OSC_EDGES - 1)) begin
              sw_cnt_reg <= 3'h0;
              sw_state_reg <= pllcgm_pkg::PLLCGM_SW_SYN;
            end else begin
              sw_cnt_reg <= 3'(sw_cnt_reg + 1'b1);
            end
          end
        end
        pllcgm_pkg::PLLCGM_SW_SYN: begin
          if (syn_rise) begin
            if (sw_cnt_reg == 3'(pllcgm_pkg::SW_SYN_EDGES - 1)) begin
              sw_cnt_reg <= 3'h0;
              synth_source_active <= sel_req;
              cpu_halt <= 1'b0;
              sw_state_reg <= pllcgm_pkg::PLLCGM_SW_RUN;
            end else begin
              sw_cnt_reg <= 3'(sw_cnt_reg + 1'b1);
            end
          end
        end
        default: begin
          sw_state_reg <= pllcgm_pkg::PLLCGM_SW_RUN;
          cpu_halt <= 1'b0;
        end
      endcase
    end
  end

  // Core follows the source, bus is half of it; all frozen mid-switch
  always_ff @(posedge clk) begin
    if (rst) begin
      core_clock <= 1'b0;
      bus_clock <= 1'b0;
      external_bus_clock_pin <= 1'b0;
    end else if (sw_state_reg == pllcgm_pkg::PLLCGM_SW_RUN) begin
      core_clock <= src_lvl;
      if (src_rise) begin
        bus_clock <= ~bus_clock;
        external_bus_clock_pin <= ~bus_clock;
      end
    end
  end

endmodule : pllcgm_top

`default_nettype wire

// [pllcgm_top_monitor.sv]
// Purpose: Concurrent checks on the clock generation and monitor block.
// Assumes: Single clk domain, synchronous active-high rst.
// Notes:   Switch bound of 300 clk holds only for pins well below clk/6.
`timescale 1ns/100ps
`default_nettype none
module pllcgm_top_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic monitor_enable,
  input wire logic por_event,
  // Status
  input wire logic lock_flag,
  input wire logic lock_irq,
  input wire logic synth_enable,
  input wire logic regulator_enable,
  input wire logic synth_source_active,
  input wire logic cpu_halt,
  input wire logic bus_clock,
  input wire logic external_bus_clock_pin,
  input wire logic self_clock_enable,
  input wire logic monitor_fail,
  input wire logic monitor_reset,
  input wire logic qc_active,
  input wire logic osc_ok
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Switch steps: halt begins, then halt ends within the bound
  sequence s_halt_start;
    $rose(cpu_halt);
  endsequence
  sequence s_halt_end;
    ##[1:300] !cpu_halt;
  endsequence
  property p_halt_end;
    s_halt_start |-> s_halt_end;
  endproperty
  // Second halted cycle on: bus clock must not move
  property p_frozen;
    cpu_halt && $past(cpu_halt) |-> $stable(bus_clock);
  endproperty
  property p_irq;
    lock_irq |-> $changed(lock_flag);
  endproperty
  property p_mon_rst;
    monitor_reset |-> monitor_fail ##1 self_clock_enable;
  endproperty
  property p_fail_en;
    monitor_fail |-> $past(monitor_enable);
  endproperty
  property p_qc_power;
    qc_active && $past(qc_active) |-> synth_enable && regulator_enable;
  endproperty
  property p_ok_exit;
    osc_ok |-> ##[0:1] !qc_active;
  endproperty
  property p_por;
    por_event |-> ##[1:2] qc_active;
  endproperty
  property p_ext;
    external_bus_clock_pin == bus_clock;
  endproperty
  property p_sel_pwr;
    synth_source_active |-> synth_enable;
  endproperty
  a_halt_end: assert property (p_halt_end) else $error("switch halt too long");
  a_frozen: assert property (p_frozen) else $error("bus clock moved in halt");
  a_irq: assert property (p_irq) else $error("lock irq without change");
  a_mon_rst: assert property (p_mon_rst) else $error("monitor reset sequence");
  a_fail_en: assert property (p_fail_en) else $error("fail while disabled");
  a_qc_power: assert property (p_qc_power) else $error("check without power");
  a_ok_exit: assert property (p_ok_exit) else $error("check kept after ok");
  a_por: assert property (p_por) else $error("por did not start check");
  a_ext: assert property (p_ext) else $error("pin differs from bus");
  a_sel_pwr: assert property (p_sel_pwr) else $error("selected synth off");
endmodule : pllcgm_top_monitor

bind pllcgm_top pllcgm_top_monitor u_mon (
  .clk(clk), .rst(rst), .monitor_enable(monitor_enable), .por_event(por_event),
  .lock_flag(lock_flag), .lock_irq(lock_irq), .synth_enable(synth_enable),
  .regulator_enable(regulator_enable), .synth_source_active(synth_source_active),
  .cpu_halt(cpu_halt), .bus_clock(bus_clock), .external_bus_clock_pin(external_bus_clock_pin),
  .self_clock_enable(self_clock_enable), .monitor_fail(monitor_fail),
  .monitor_reset(monitor_reset), .qc_active(qc_active), .osc_ok(osc_ok)
);
`default_nettype wire

// [pllcgm_top_bench.sv]
// Purpose: Self-checking bench for the clock generation and monitor block.
// Assumes: Pins made from clk: osc period 16 clk, synth period 8 clk.
// Notes:   Short monitor, window and edge counts keep the run brief.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, exp, got); end end
module pllcgm_top_bench;
  localparam int MON = 50, WIN = 200, OK = 16, QMAX = 3;
  logic clk, rst, osc_clock, synth_clock, osc_run, por_event, lvr_event, stop_wake_event;
  logic [3:0] reference_divider;
  logic [5:0] loop_multiplier;
  logic synth_power_on, auto_bandwidth, acquire_mode, lock_change_irq_enable;
  logic synth_source_select, monitor_enable, self_clock_enable_wr, self_clock_enable_wdata;
  logic lock_flag, track_flag, lock_irq, filter_acquire, synth_enable, regulator_enable;
  logic synth_source_active, core_clock, bus_clock, external_bus_clock_pin, cpu_halt;
  logic self_clock_enable, self_clock_mode, monitor_fail, monitor_reset, qc_active;
  logic osc_ok, qc_fail, bus_q, core_q;
  int errors, n_checks, oc, sc, n_irq, n_mf, n_mr, n_ok, n_bus, n_core, b, c, t;

  pllcgm_top #(.MON_CYC(MON), .QC_WIN(WIN), .QC_OK(OK), .QC_MAX(QMAX)) DUT (
    .clk(clk), .rst(rst), .osc_clock(osc_clock), .synth_clock(synth_clock),
    .reference_divider(reference_divider), .loop_multiplier(loop_multiplier),
    .synth_power_on(synth_power_on), .auto_bandwidth(auto_bandwidth),
    .acquire_mode(acquire_mode), .lock_change_irq_enable(lock_change_irq_enable),
    .synth_source_select(synth_source_select), .monitor_enable(monitor_enable),
    .self_clock_enable_wr(self_clock_enable_wr),
    .self_clock_enable_wdata(self_clock_enable_wdata), .por_event(por_event),
    .lvr_event(lvr_event), .stop_wake_event(stop_wake_event), .lock_flag(lock_flag),
    .track_flag(track_flag), .lock_irq(lock_irq), .filter_acquire(filter_acquire),
    .synth_enable(synth_enable), .regulator_enable(regulator_enable),
    .synth_source_active(synth_source_active), .core_clock(core_clock),
    .bus_clock(bus_clock), .external_bus_clock_pin(external_bus_clock_pin),
    .cpu_halt(cpu_halt), .self_clock_enable(self_clock_enable),
    .self_clock_mode(self_clock_mode), .monitor_fail(monitor_fail),
    .monitor_reset(monitor_reset), .qc_active(qc_active), .osc_ok(osc_ok), .qc_fail(qc_fail)
  );

  // ****************************************************************
  // Clocks, pins and event counters
  // ****************************************************************
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Stopped oscillator holds its level, as a dead crystal would
  always @(posedge clk) begin
    oc <= (oc == 7) ? 0 : oc + 1;
    sc <= (sc == 3) ? 0 : sc + 1;
    if (oc == 7 && osc_run) osc_clock <= ~osc_clock;
    if (sc == 3) synth_clock <= ~synth_clock;
    n_irq <= n_irq + int'(lock_irq);
    n_mf <= n_mf + int'(monitor_fail);
    n_mr <= n_mr + int'(monitor_reset);
    n_ok <= n_ok + int'(osc_ok);
    bus_q <= bus_clock;
    core_q <= core_clock;
    n_bus <= n_bus + int'(bus_clock && !bus_q);
    n_core <= n_core + int'(core_clock && !core_q);
  end

  // ****************************************************************
  // Helpers and scenarios
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Bounded wait; returns elapsed cycles
  task automatic wait_val(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_val

  task t_lock;
    @(posedge clk);
    auto_bandwidth <= 1;
    lock_change_irq_enable <= 1;
    synth_power_on <= 1;
    wait_val(lock_flag, 1, 3000, t);
    `CHK("lock", 1'h1, lock_flag)
    wait_val(track_flag, 1, 600, t);
    `CHK("track", 1'h1, track_flag)
    `CHK("filter", 1'h0, filter_acquire)
    @(posedge clk);
    loop_multiplier <= 6'h1;
    wait_val(track_flag, 0, 1500, t);
    `CHK("untrack", 1'h0, track_flag)
    `CHK("unlock", 1'h0, lock_flag)
    @(posedge clk);
    reference_divider <= 4'h1;
    wait_val(lock_flag, 1, 2000, t);
    `CHK("relock", 1'h1, lock_flag)
    cyc(1);
    `CHK("irqs", 3, n_irq)
    // Masked change must stay silent
    @(posedge clk);
    lock_change_irq_enable <= 0;
    reference_divider <= 4'h0;
    wait_val(lock_flag, 0, 1500, t);
    `CHK("masked", 3, n_irq)
    @(posedge clk);
    lock_change_irq_enable <= 1;
    loop_multiplier <= 6'h0;
    wait_val(lock_flag, 1, 2000, t);
    cyc(1);
    `CHK("irq_on", 4, n_irq)
  endtask : t_lock

  task t_manual;
    @(posedge clk);
    auto_bandwidth <= 0;
    cyc(3);
    `CHK("man_trk", 1'h0, track_flag)
    `CHK("man_acq", 1'h1, filter_acquire)
    @(posedge clk);
    acquire_mode <= 0;
    cyc(3);
    `CHK("man_trk1", 1'h1, track_flag)
    `CHK("man_acq0", 1'h0, filter_acquire)
    @(posedge clk);
    auto_bandwidth <= 1;
  endtask : t_manual

  task t_switch;
    `CHK("pre_sel_lock", 1'h1, lock_flag)
    @(posedge clk);
    synth_source_select <= 1;
    cyc(2);
    `CHK("halt", 1'h1, cpu_halt)
    wait_val(synth_source_active, 1, 300, t);
    `CHK("sel", 1'h1, synth_source_active)
    `CHK("run", 1'h0, cpu_halt)
    @(posedge clk);
    synth_power_on <= 0;
    cyc(4);
    `CHK("keep_on", 1'h1, synth_enable)
    b = n_bus;
    c = n_core;
    cyc(160);
    `CHK("bus_syn", 1'h1, (n_bus - b) inside {[9:11]})
    `CHK("core_syn", 1'h1, (n_core - c) inside {[19:21]})
    @(posedge clk);
    synth_power_on <= 1;
    synth_source_select <= 0;
    wait_val(synth_source_active, 0, 300, t);
    b = n_bus;
    cyc(160);
    `CHK("bus_osc", 1'h1, (n_bus - b) inside {[4:6]})
  endtask : t_switch

  task t_monitor;
    @(posedge clk);
    osc_run <= 0;
    cyc(200);
    `CHK("off_nofail", 0, n_mf)
    @(posedge clk);
    osc_run <= 1;
    monitor_enable <= 1;
    self_clock_enable_wr <= 1;
    self_clock_enable_wdata <= 0;
    @(posedge clk);
    self_clock_enable_wr <= 0;
    cyc(100);
    `CHK("sce_wr", 1'h0, self_clock_enable)
    `CHK("edges_nofail", 0, n_mf)
    @(posedge clk);
    osc_run <= 0;
    wait_val(monitor_reset, 1, MON + 20, t);
    `CHK("mon_rst", 1'h1, monitor_reset)
    cyc(2);
    `CHK("sce_set", 1'h1, self_clock_enable)
    `CHK("qc_cm", 1'h1, qc_active)
    @(posedge clk);
    osc_run <= 1;
    wait_val(qc_active, 0, WIN * 8 + 400, t);
    `CHK("ok1", 1, n_ok)
    // Second loss with self-clock allowed
    @(posedge clk);
    osc_run <= 0;
    wait_val(self_clock_mode, 1, MON + 20, t);
    `CHK("scm", 1'h1, self_clock_mode)
    `CHK("no_rst", 1, n_mr)
    b = n_bus;
    cyc(160);
    `CHK("scm_bus", 1'h1, (n_bus - b) inside {[9:11]})
    `CHK("qc_par", 1'h1, qc_active)
    `CHK("vreg", 1'h1, regulator_enable)
    `CHK("mf_cnt", 2, n_mf)
    @(posedge clk);
    osc_run <= 1;
    wait_val(self_clock_mode, 0, WIN * 8 + 400, t);
    `CHK("scm_exit", 1'h0, self_clock_mode)
    `CHK("ok2", 2, n_ok)
  endtask : t_monitor

  task t_qc;
    @(posedge clk);
    monitor_enable <= 0;
    osc_run <= 0;
    por_event <= 1;
    @(posedge clk);
    por_event <= 0;
    cyc(3);
    `CHK("qc_por", 1'h1, qc_active)
    wait_val(qc_fail, 1, QMAX * WIN * 8 + 500, t);
    `CHK("qc_fail", 1'h1, qc_fail)
    `CHK("win_len", 1'h1, t inside {[4700:4900]})
    @(posedge clk);
    osc_run <= 1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      lvr_event <= (k == 0);
      stop_wake_event <= (k == 1);
      @(posedge clk);
      lvr_event <= 0;
      stop_wake_event <= 0;
      cyc(2);
      `CHK("qc_trig", 1'h1, qc_active)
      wait_val(qc_active, 0, 600, t);
      `CHK("ok_time", 1'h1, t inside {[220:300]})
    end
  endtask : t_qc

  task finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // Main sequence; acquisition chosen before power on
  initial begin
    {rst, osc_clock, synth_clock, osc_run} = 4'h9;
    {por_event, lvr_event, stop_wake_event, synth_power_on, auto_bandwidth} = 5'h00;
    acquire_mode = 1;
    {lock_change_irq_enable, synth_source_select, monitor_enable} = 3'h0;
    {self_clock_enable_wr, self_clock_enable_wdata, reference_divider} = 6'h00;
    loop_multiplier = 6'h0;
    repeat (10) @(posedge clk);
    rst <= 0;
    cyc(1);
    `CHK("rst_sce", 1'h1, self_clock_enable)
    `CHK("rst_sel", 1'h0, synth_source_active)
    t_lock();
    t_manual();
    t_switch();
    t_monitor();
    t_qc();
    finish_test();
  end
  // Watchdog well past the expected run
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule : pllcgm_top_bench
`default_nettype wire
